// File: pgiu_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pgiu_map.vh"
module pgiu_top (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // digital pins of ports 0 and 1, asynchronous
  input wire [`PGIU_NPIN-1:0] pin_in,
  // system_config_block source selectors, 6 bits per channel
  input wire [`PGIU_NCH*`PGIU_SELW-1:0] src_sel,
  // pin channel configuration, one bit per channel
  input wire [`PGIU_NCH-1:0] ch_level_mode,
  input wire [`PGIU_NCH-1:0] ch_rise_en,
  input wire [`PGIU_NCH-1:0] ch_fall_en,
  input wire [`PGIU_NCH-1:0] ch_level_high,
  input wire [`PGIU_NCH-1:0] ch_clr,
  // pattern engine configuration
  input wire pm_enable,
  input wire [`PGIU_NSLICE*3-1:0] pm_mode,
  input wire [`PGIU_NSLICE*3-1:0] pm_src,
  input wire [`PGIU_NSLICE-1:0] pm_endpoint,
  input wire pm_event_en,
  // group units a and b
  input wire [`PGIU_NPIN-1:0] grp_a_enable,
  input wire [`PGIU_NPIN-1:0] grp_a_pol_high,
  input wire grp_a_and_mode,
  input wire grp_a_edge_mode,
  input wire grp_a_clr,
  input wire [`PGIU_NPIN-1:0] grp_b_enable,
  input wire [`PGIU_NPIN-1:0] grp_b_pol_high,
  input wire grp_b_and_mode,
  input wire grp_b_edge_mode,
  input wire grp_b_clr,
  // power state
  input wire sleeping,
  // lines to vectored_irq_ctrl and power control
  output reg [`PGIU_NCH-1:0] pin_irq_r,
  output reg [`PGIU_NCH-1:0] ch_rise_stat_r,
  output reg [`PGIU_NCH-1:0] ch_fall_stat_r,
  output reg [`PGIU_NSLICE-1:0] pm_term_irq_r,
  output reg cpu_event_input_r,
  output reg grp_a_irq_r,
  output reg grp_b_irq_r,
  output reg wake_req_r,
  output reg wake_async_r
);
  reg [`PGIU_NPIN-1:0] meta_r;
  reg [`PGIU_NPIN-1:0] sync_r;
  reg [`PGIU_NCH-1:0] ch_d_r;
  reg [`PGIU_NSLICE-1:0] pm_sticky_r;
  reg [`PGIU_NSLICE-1:0] pm_term_d_r;
  wire [`PGIU_NCH-1:0] ch_now;
  wire [`PGIU_NCH-1:0] ch_rise;
  wire [`PGIU_NCH-1:0] ch_fall;
  wire [`PGIU_NSLICE-1:0] slice_true;
  wire [`PGIU_NSLICE-1:0] term_true;
  wire grp_a_irq;
  wire grp_b_irq;
  wire grp_a_wake;
  wire grp_b_wake;

  // pick one synchronised pin for a channel
  function pick;
    input [`PGIU_NPIN-1:0] pins;
    input [`PGIU_SELW-1:0] sel;
    begin
      pick = pins[sel];
    end
  endfunction

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= `PGIU_RST_GRP;
      sync_r <= `PGIU_RST_GRP;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `PGIU_NCH; i = i + 1) begin : g_ch
      // source selector picks any port 0/1 pin
      assign ch_now[i] = pick(sync_r, src_sel[i*`PGIU_SELW +: `PGIU_SELW]);
      assign ch_rise[i] = ch_now[i] & ~ch_d_r[i];
      assign ch_fall[i] = ~ch_now[i] & ch_d_r[i];
    end
  endgenerate

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch_d_r <= `PGIU_RST_WORD;
      ch_rise_stat_r <= `PGIU_RST_WORD;
      ch_fall_stat_r <= `PGIU_RST_WORD;
      pin_irq_r <= `PGIU_RST_WORD;
    end else begin
      ch_d_r <= ch_now;
      // sticky edge flags, a new edge beats the clear
      ch_rise_stat_r <= (ch_rise_stat_r & ~ch_clr) | (ch_rise & ch_rise_en);
      ch_fall_stat_r <= (ch_fall_stat_r & ~ch_clr) | (ch_fall & ch_fall_en);
      // edge channels use enabled edge flags
      // level channels follow the chosen polarity
      pin_irq_r <= (~ch_level_mode & ((ch_rise_stat_r & ~ch_clr) | (ch_rise & ch_rise_en)
                                    | (ch_fall_stat_r & ~ch_clr) | (ch_fall & ch_fall_en)))
                 | (ch_level_mode & ~(ch_now ^ ch_level_high));
    end
  end

  // per-slice condition on one of the eight channel inputs
  generate
    for (i = 0; i < `PGIU_NSLICE; i = i + 1) begin : g_slice
      wire [2:0] md;
      wire in_now;
      wire in_rise;
      wire in_fall;
      assign md = pm_mode[i*3 +: 3];
      assign in_now = ch_now[pm_src[i*3 +: 3]];
      assign in_rise = ch_rise[pm_src[i*3 +: 3]];
      assign in_fall = ch_fall[pm_src[i*3 +: 3]];
      assign slice_true[i] =
        (md == `PGIU_PM_CONST_HI) ? 1'b1 :
        (md == `PGIU_PM_STICKY_RISE) ? (pm_sticky_r[i] | in_rise) :
        (md == `PGIU_PM_STICKY_FALL) ? (pm_sticky_r[i] | in_fall) :
        (md == `PGIU_PM_STICKY_BOTH) ? (pm_sticky_r[i] | in_rise | in_fall) :
        (md == `PGIU_PM_HIGH) ? in_now :
        (md == `PGIU_PM_LOW) ? ~in_now :
        (md == `PGIU_PM_CONST_LO) ? 1'b0 :
        (in_rise | in_fall);
    end
  endgenerate

  // product terms: and of slices back to previous endpoint
  generate
    for (i = 0; i < `PGIU_NSLICE; i = i + 1) begin : g_term
      wire [`PGIU_NSLICE-1:0] member;
      genvar j;
      for (j = 0; j < `PGIU_NSLICE; j = j + 1) begin : g_mem
        // slice j belongs to term i if no endpoint lies in [j, i)
        if (j > i) begin : g_out
          assign member[j] = 1'b0;
        end else if (j == i) begin : g_self
          assign member[j] = 1'b1;
        end else begin : g_prev
          assign member[j] = member[j+1] & ~pm_endpoint[j];
        end
      end
      assign term_true[i] = pm_enable & pm_endpoint[i] & ((slice_true | ~member) == 8'hFF);
    end
  endgenerate

  // each term has its own request
  // any match may pulse the cpu event input
  // pattern engine takes no part in wake-up
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pm_sticky_r <= `PGIU_RST_WORD;
      pm_term_d_r <= `PGIU_RST_WORD;
      pm_term_irq_r <= `PGIU_RST_WORD;
      cpu_event_input_r <= 1'b0;
    end else begin
      // sticky edge memories are dropped while the engine is off
      pm_sticky_r <= pm_enable ? slice_true : `PGIU_RST_WORD;
      pm_term_d_r <= term_true;
      pm_term_irq_r <= term_true;
      cpu_event_input_r <= pm_event_en & |(term_true & ~pm_term_d_r);
    end
  end

  // each with its own enable and polarity
  // full-width pin vector, no limit on enabled pins
  pgiu_group u_grp_a (
    .clk(clk),
    .arst_n(arst_n),
    .pin_raw(pin_in),
    .pin_sync(sync_r),
    .enable(grp_a_enable),
    .pol_high(grp_a_pol_high),
    .and_mode(grp_a_and_mode),
    .edge_mode(grp_a_edge_mode),
    .sleeping(sleeping),
    .clr_stat(grp_a_clr),
    .irq_r(grp_a_irq),
    .wake_async(grp_a_wake)
  );

  pgiu_group u_grp_b (
    .clk(clk),
    .arst_n(arst_n),
    .pin_raw(pin_in),
    .pin_sync(sync_r),
    .enable(grp_b_enable),
    .pol_high(grp_b_pol_high),
    .and_mode(grp_b_and_mode),
    .edge_mode(grp_b_edge_mode),
    .sleeping(sleeping),
    .clr_stat(grp_b_clr),
    .irq_r(grp_b_irq),
    .wake_async(grp_b_wake)
  );

  // wake from pin channels and groups
  // all results settle in one clock
  // group lines follow their cleared status
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      grp_a_irq_r <= 1'b0;
      grp_b_irq_r <= 1'b0;
      wake_req_r <= 1'b0;
      wake_async_r <= 1'b0;
    end else begin
      grp_a_irq_r <= grp_a_irq;
      grp_b_irq_r <= grp_b_irq;
      wake_req_r <= sleeping & (|pin_irq_r | grp_a_irq | grp_b_irq);
      // registered copy; the raw async path lives inside the group unit
      wake_async_r <= grp_a_wake | grp_b_wake;
    end
  end
endmodule
`default_nettype wire

// File: pgiu_map.vh
`ifndef PGIU_MAP_VH
`define PGIU_MAP_VH
// channel and pin counts
`define PGIU_NCH 8
`define PGIU_NPIN 64
`define PGIU_SELW 6
// pattern slice count and per-slice mode encodings
`define PGIU_NSLICE 8
`define PGIU_PM_CONST_HI 3'h0
`define PGIU_PM_STICKY_RISE 3'h1
`define PGIU_PM_STICKY_FALL 3'h2
`define PGIU_PM_STICKY_BOTH 3'h3
`define PGIU_PM_HIGH 3'h4
`define PGIU_PM_LOW 3'h5
`define PGIU_PM_CONST_LO 3'h6
`define PGIU_PM_EVENT 3'h7
// pin interrupt edge selection bit positions
`define PGIU_EDGE_RISE 0
`define PGIU_EDGE_FALL 1
// reset values
`define PGIU_RST_SEL 6'h00
`define PGIU_RST_WORD 8'h00
`define PGIU_RST_GRP 64'h0000000000000000
`endif

// File: pgiu_group.v
`timescale 1ns/1ps
`default_nettype none
`include "pgiu_map.vh"
// one group interrupt unit: enable, polarity, or/and combine, level/edge output
module pgiu_group (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // raw pins for asynchronous wake, synchronised pins for the request
  input wire [`PGIU_NPIN-1:0] pin_raw,
  input wire [`PGIU_NPIN-1:0] pin_sync,
  // configuration
  input wire [`PGIU_NPIN-1:0] enable,
  input wire [`PGIU_NPIN-1:0] pol_high,
  input wire and_mode,
  input wire edge_mode,
  input wire sleeping,
  input wire clr_stat,
  // results
  output reg irq_r,
  output wire wake_async
);
  reg match_d_r;
  reg woke_r;
  wire match_now;
  wire match_raw;
  wire [`PGIU_NPIN-1:0] act_s;
  wire [`PGIU_NPIN-1:0] act_a;

  // active-level view of every pin; disabled pins never count
  assign act_s = ~(pin_sync ^ pol_high);
  assign act_a = ~(pin_raw ^ pol_high);

  // any number of pins may contribute; and-mode ignores disabled ones
  assign match_now = and_mode ? ((|enable) && ((act_s | ~enable) == {`PGIU_NPIN{1'b1}}))
                              : |(act_s & enable);
  assign match_raw = and_mode ? ((|enable) && ((act_a | ~enable) == {`PGIU_NPIN{1'b1}}))
                              : |(act_a & enable);

  // asynchronous wake path
  // combinational on raw pins so it works with the clock stopped
  assign wake_async = sleeping & match_raw;

  // write-one clear; a new match wins over clear except while sleeping
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match_d_r <= 1'b0;
      woke_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      match_d_r <= match_now;
      // edge mode: a match still present on the last sleeping cycle raises the request on the first cycle after sleeping drops
      woke_r <= sleeping & match_now;
      if (edge_mode) begin
        if (match_now && !match_d_r && !sleeping)
          irq_r <= 1'b1;
        else if (woke_r && !sleeping)
          irq_r <= 1'b1;
        else if (clr_stat)
          irq_r <= 1'b0;
      end else begin
        if (match_now && !sleeping)
          irq_r <= 1'b1;
        else if (clr_stat)
          irq_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: pgiu_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgiu_map.vh"
module pgiu_properties (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration seen by the block
  input wire logic [`PGIU_NCH-1:0] ch_level_mode,
  input wire logic [`PGIU_NCH-1:0] ch_clr,
  input wire logic pm_enable,
  input wire logic pm_event_en,
  input wire logic grp_b_edge_mode,
  input wire logic grp_b_clr,
  input wire logic sleeping,
  // request lines
  input wire logic [`PGIU_NCH-1:0] pin_irq_r,
  input wire logic [`PGIU_NCH-1:0] ch_rise_stat_r,
  input wire logic [`PGIU_NCH-1:0] ch_fall_stat_r,
  input wire logic [`PGIU_NSLICE-1:0] pm_term_irq_r,
  input wire logic cpu_event_input_r,
  input wire logic grp_a_irq_r,
  input wire logic grp_b_irq_r,
  input wire logic wake_req_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // flags that must survive the next edge
  wire [`PGIU_NCH-1:0] keep_rise = ch_rise_stat_r & ~ch_clr;
  // engine or event switch held off long enough to drain the pipe
  sequence pm_off_s; !pm_enable [*4]; endsequence
  sequence ev_off_s; !pm_event_en [*4]; endsequence
  rise_sticky_a: assert property (1'b1 |=>
    (ch_rise_stat_r & $past(keep_rise)) == $past(keep_rise)) else $error("edge flag lost");
  edge_irq_a: assert property (!ch_level_mode[0] && !$past(ch_level_mode[0]) |->
    pin_irq_r[0] == (ch_rise_stat_r[0] | ch_fall_stat_r[0])) else $error("edge irq mismatch");
  pm_quiet_a: assert property (pm_off_s |-> pm_term_irq_r == 8'h00)
    else $error("term irq while engine off");
  event_quiet_a: assert property (ev_off_s |-> !cpu_event_input_r)
    else $error("event while disabled");
  pin_wake_a: assert property ($rose(pin_irq_r[0]) && sleeping |-> ##[0:3] wake_req_r)
    else $error("no wake for pin irq");
  grp_a_sleep_a: assert property (sleeping && $past(sleeping) |-> !$rose(grp_a_irq_r))
    else $error("group a irq while asleep");
  grp_b_sleep_a: assert property (sleeping && $past(sleeping) |-> !$rose(grp_b_irq_r))
    else $error("group b irq while asleep");
  grp_clr_a: assert property (grp_b_clr && grp_b_edge_mode |-> ##2 !grp_b_irq_r)
    else $error("group b irq not cleared");
endmodule
bind pgiu_top pgiu_properties u_props (.clk(clk), .arst_n(arst_n), .ch_level_mode(ch_level_mode),
  .ch_clr(ch_clr), .pm_enable(pm_enable), .pm_event_en(pm_event_en),
  .grp_b_edge_mode(grp_b_edge_mode), .grp_b_clr(grp_b_clr), .sleeping(sleeping),
  .pin_irq_r(pin_irq_r), .ch_rise_stat_r(ch_rise_stat_r), .ch_fall_stat_r(ch_fall_stat_r),
  .pm_term_irq_r(pm_term_irq_r), .cpu_event_input_r(cpu_event_input_r),
  .grp_a_irq_r(grp_a_irq_r), .grp_b_irq_r(grp_b_irq_r), .wake_req_r(wake_req_r));
`default_nettype wire

// File: pgiu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pgiu_pin_model (
  // clock
  input wire logic clk,
  // one pin change per strobe
  input wire logic [5:0] pick,
  input wire logic lvl,
  input wire logic stb,
  // pin levels of ports 0 and 1
  output logic [63:0] pins_out
);
  // outside pins have no reset, start low
  initial pins_out = 64'h0;
  always @(posedge clk) begin
    if (stb) begin
      pins_out[pick] <= lvl;
    end
  end
endmodule
`default_nettype wire

// File: test_pin_and_group_interrupt_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "pgiu_map.vh"
module test_pin_and_group_interrupt_unit;
  // clock, reset and pin requests
  logic clk = 1'h0, arst_n = 1'h0, lvl = 1'h0, stb = 1'h0;
  logic [5:0] pick = 6'h00;
  logic [63:0] pin_in;
  // configuration, quiet at time zero
  logic [47:0] src_sel = 48'h0;
  logic [7:0] ch_level_mode = 8'h00, ch_rise_en = 8'h00, ch_fall_en = 8'h00;
  logic [7:0] ch_level_high = 8'h00, ch_clr = 8'h00, pm_endpoint = 8'h00;
  logic [23:0] pm_mode = 24'h0, pm_src = 24'h0;
  logic [63:0] grp_a_enable = 64'h0, grp_a_pol_high = 64'h0;
  logic [63:0] grp_b_enable = 64'h0, grp_b_pol_high = 64'h0;
  logic pm_enable = 1'h0, pm_event_en = 1'h0, sleeping = 1'h0;
  logic grp_a_and_mode = 1'h0, grp_a_edge_mode = 1'h0, grp_a_clr = 1'h0;
  logic grp_b_and_mode = 1'h0, grp_b_edge_mode = 1'h0, grp_b_clr = 1'h0;
  // block outputs
  wire [7:0] pin_irq_r, ch_rise_stat_r, ch_fall_stat_r, pm_term_irq_r;
  wire cpu_event_input_r, grp_a_irq_r, grp_b_irq_r, wake_req_r, wake_async_r;
  int bad_count = 0, num_checks = 0, cycles = 0;
  // 50 ns period
  always #25 clk = ~clk;
  pgiu_pin_model partner (.clk, .pick, .lvl, .stb, .pins_out(pin_in));
  pgiu_top dut (.clk, .arst_n, .pin_in, .src_sel, .ch_level_mode, .ch_rise_en, .ch_fall_en,
    .ch_level_high, .ch_clr, .pm_enable, .pm_mode, .pm_src, .pm_endpoint, .pm_event_en,
    .grp_a_enable, .grp_a_pol_high, .grp_a_and_mode, .grp_a_edge_mode, .grp_a_clr,
    .grp_b_enable, .grp_b_pol_high, .grp_b_and_mode, .grp_b_edge_mode, .grp_b_clr, .sleeping,
    .pin_irq_r, .ch_rise_stat_r, .ch_fall_stat_r, .pm_term_irq_r, .cpu_event_input_r,
    .grp_a_irq_r, .grp_b_irq_r, .wake_req_r, .wake_async_r);
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  // wait edges, then look once the updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pin(input logic [5:0] idx, input logic v);
    @(posedge clk);
    pick <= idx;
    lvl <= v;
    stb <= 1'h1;
    @(posedge clk);
    stb <= 1'h0;
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard; the run needs under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  // ch0 both edges on pin 40, ch1 low-active level on pin 3, group a on pins 5 and 6, group b on pin 5
  task automatic setup;
    @(posedge clk);
    src_sel <= {36'h0, 6'h03, 6'h28};
    ch_level_mode <= 8'h02;
    ch_rise_en <= 8'h01;
    ch_fall_en <= 8'h01;
    pm_mode <= {21'h0, `PGIU_PM_HIGH};
    pm_src <= 24'h000001;
    pm_endpoint <= 8'h01;
    pm_event_en <= 1'h1;
    grp_a_enable <= 64'h60;
    grp_a_pol_high <= 64'h20;
    grp_a_and_mode <= 1'h1;
    grp_b_enable <= 64'h20;
    grp_b_pol_high <= 64'h20;
    grp_b_edge_mode <= 1'h1;
  endtask
  task automatic test_edge;
    @(posedge clk);
    sleeping <= 1'h1;
    pin(6'h28, 1'h1);
    cyc(5);
    check({ch_rise_stat_r[0], pin_irq_r[0], wake_req_r}, 8'h07);
    pin(6'h28, 1'h0);
    cyc(5);
    check({ch_rise_stat_r[0], ch_fall_stat_r[0]}, 8'h03);
    @(posedge clk);
    ch_clr <= 8'h01;
    sleeping <= 1'h0;
    @(posedge clk);
    ch_clr <= 8'h00;
    cyc(1);
    check({ch_rise_stat_r[0], ch_fall_stat_r[0], pin_irq_r[0]}, 8'h00);
    $display("edge test done");
  endtask
  task automatic test_level;
    cyc(1);
    check(pin_irq_r[1], 1'h1);
    pin(6'h03, 1'h1);
    cyc(5);
    check(pin_irq_r[1], 1'h0);
    // same pin, polarity flipped to active high
    @(posedge clk);
    ch_level_high <= 8'h02;
    cyc(4);
    check(pin_irq_r[1], 1'h1);
    $display("level test done");
  endtask
  task automatic test_pattern;
    int ev;
    ev = 0;
    @(posedge clk);
    pm_enable <= 1'h1;
    repeat (6) begin
      cyc(1);
      if (cpu_event_input_r === 1'h1) ev++;
    end
    check(pm_term_irq_r, 8'h01);
    check(ev != 0, 1'h1);
    check(wake_req_r, 1'h0);
    pin(6'h03, 1'h0);
    cyc(5);
    check(pm_term_irq_r, 8'h00);
    $display("pattern test done");
  endtask
  task automatic test_group;
    @(posedge clk);
    pm_enable <= 1'h0;
    sleeping <= 1'h1;
    pin(6'h05, 1'h1);
    cyc(6);
    check({grp_a_irq_r, grp_b_irq_r, wake_async_r}, 8'h01);
    @(posedge clk);
    sleeping <= 1'h0;
    cyc(6);
    check({grp_a_irq_r, grp_b_irq_r}, 8'h03);
    @(posedge clk);
    grp_b_clr <= 1'h1;
    @(posedge clk);
    grp_b_clr <= 1'h0;
    cyc(2);
    check({grp_a_irq_r, grp_b_irq_r}, 8'h02);
    $display("group test done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    setup();
    cyc(4);
    test_edge();
    test_level();
    test_pattern();
    test_group();
    print_verdict();
  end
endmodule
`default_nettype wire
